// file: hdl/dead_time_phase.sv
// one half-bridge phase: command decode, bootstrap blanking and dead-time counter
`timescale 1ns/100ps
module dead_time_phase (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // control from the sequencer
  input wire logic drive_en,
  input wire logic [gate_drive_pkg::DT_W-1:0] dt_cycles,
  // synchronised phase inputs
  input wire logic high_side_cmd,
  input wire logic low_side_cmd,
  input wire logic bootstrap_low,
  // gate enables
  output logic high_gate_out,
  output logic low_gate_out
);
  logic high_ff, nxt_high;  // high-side gate on
  logic low_ff, nxt_low;    // low-side gate on
  logic [gate_drive_pkg::DT_W-1:0] dt_cnt_ff, nxt_dt_cnt;  // remaining off cycles
  logic want_high, want_low;

  // decode: only unequal commands drive a gate
  assign want_high = drive_en & high_side_cmd & ~low_side_cmd & ~bootstrap_low;
  assign want_low = drive_en & low_side_cmd & ~high_side_cmd;

  // next gate state; a turn-off loads the counter and blocks both gates until it expires
  always_comb begin
    nxt_high = high_ff;
    nxt_low = low_ff;
    nxt_dt_cnt = dt_cnt_ff;
    if (dt_cnt_ff != '0) begin
      nxt_dt_cnt = dt_cnt_ff - 1'b1;
      nxt_high = 1'b0;
      nxt_low = 1'b0;
    end else if ((high_ff & ~want_high) | (low_ff & ~want_low)) begin
      // load dt-1 so the gates stay off for exactly dt cycles
      nxt_dt_cnt = dt_cycles - 1'b1;
      nxt_high = 1'b0;
      nxt_low = 1'b0;
    end else begin
      nxt_high = want_high;
      nxt_low = want_low;
    end
  end

  // register the gate state
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      high_ff <= 1'b0;
      low_ff <= 1'b0;
      dt_cnt_ff <= '0;
    end else begin
      high_ff <= nxt_high;
      low_ff <= nxt_low;
      dt_cnt_ff <= nxt_dt_cnt;
    end
  end

  assign high_gate_out = high_ff;
  assign low_gate_out = low_ff;

  // a gate turn-off followed by a quiet window
  sequence s_quiet;
    (!high_ff && !low_ff) [*8];
  endsequence

  property p_no_overlap;
    @(posedge ref_clk) disable iff (!rst_n) !(high_ff && low_ff);
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("both gates of a phase on");

  property p_dead_after_high;
    @(posedge ref_clk) disable iff (!rst_n) $fell(high_ff) |-> s_quiet;
  endproperty
  a_dead_after_high: assert property (p_dead_after_high) else $error("dead time short after high-side off");

  property p_dead_after_low;
    @(posedge ref_clk) disable iff (!rst_n) $fell(low_ff) |-> s_quiet;
  endproperty
  a_dead_after_low: assert property (p_dead_after_low) else $error("dead time short after low-side off");

  property p_count_blocks;
    @(posedge ref_clk) disable iff (!rst_n) (dt_cnt_ff != '0) |=> !high_ff && !low_ff;
  endproperty
  a_count_blocks: assert property (p_count_blocks) else $error("gate on while dead-time count runs");

  property p_bst_blank;
    @(posedge ref_clk) disable iff (!rst_n) bootstrap_low |=> !high_ff;
  endproperty
  a_bst_blank: assert property (p_bst_blank) else $error("high side on under bootstrap undervoltage");

  property p_decode_low;
    @(posedge ref_clk) disable iff (!rst_n)
      (dt_cnt_ff == '0) && !high_ff && want_low |=> low_ff;
  endproperty
  a_decode_low: assert property (p_decode_low) else $error("low side not driven for low command");
endmodule

// file: hdl/three_phase_gate_drive_control.sv
// top of the three-phase gate drive control: sync, sequencer, dead-time select, fault
// Function
// - ignore commands, gates off 70 us after reset; faults still reported
// - sleep request disables everything, ignores inputs
// - unequal commands drive one gate, equal none
// - dead time between turn-off and turn-on
// - grounded select 77 ns, open 6 us
// - fault pin low while fault present
// - bootstrap low blanks high side, no fault
// - supply low: gates off, fault, auto resume
// - supply low drives all gates low
// - over-temperature: gates off, fault, auto resume
`timescale 1ns/100ps
module three_phase_gate_drive_control #(
  parameter int SETTLE_CYCLES = gate_drive_pkg::SETTLE_CYCLES  // shorten for simulation
) (
  // clock and reset (reset is the supply-good indication)
  input wire logic ref_clk,
  input wire logic rst_n,
  // asynchronous pins
  input wire gate_drive_pkg::pin_in_t pins_in,
  // gate enables
  output gate_drive_pkg::gate_out_t gates,
  // open-drain active-low fault report
  output logic error_report_n_out,
  output logic error_report_n_oe
);
  localparam logic [gate_drive_pkg::SETTLE_W-1:0] SETTLE_LOAD = gate_drive_pkg::SETTLE_W'(SETTLE_CYCLES - 1);
  localparam logic [gate_drive_pkg::DT_W-1:0] DT_GND_LOAD = gate_drive_pkg::DT_W'(gate_drive_pkg::DT_GND_CYCLES);
  localparam logic [gate_drive_pkg::DT_W-1:0] DT_OPEN_LOAD = gate_drive_pkg::DT_W'(gate_drive_pkg::DT_OPEN_CYCLES);

  gate_drive_pkg::pin_in_t sync1_ff, sync2_ff;  // two-stage synchroniser
  gate_drive_pkg::seq_state_t state_ff, nxt_state;  // sleep / settle / run
  logic [gate_drive_pkg::SETTLE_W-1:0] settle_ff, nxt_settle;  // settle countdown
  logic [gate_drive_pkg::DT_W-1:0] dt_cycles_ff, nxt_dt_cycles;  // selected dead time
  logic fault_ff, nxt_fault;  // fault report level
  logic drive_en;  // gates may be driven
  logic [15:0] dt_ns_x;  // dead time in ns, resistor mode

  // pins are asynchronous; only sync2_ff is read by logic
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sync1_ff <= gate_drive_pkg::pin_in_t'(gate_drive_pkg::SYNC_RESET_VAL);
      sync2_ff <= gate_drive_pkg::pin_in_t'(gate_drive_pkg::SYNC_RESET_VAL);
    end else begin
      sync1_ff <= pins_in;
      sync2_ff <= sync1_ff;
    end
  end

  // sequencer: sleep holds everything off, wake and reset both pass a settle window
  always_comb begin
    nxt_state = state_ff;
    nxt_settle = settle_ff;
    case (state_ff)
      gate_drive_pkg::ST_SLEEP: begin
        nxt_settle = SETTLE_LOAD;
        if (sync2_ff.low_power_request_n) begin
          nxt_state = gate_drive_pkg::ST_SETTLE;  // wake: settle again before running
        end
      end
      gate_drive_pkg::ST_SETTLE: begin
        if (!sync2_ff.low_power_request_n) begin
          nxt_state = gate_drive_pkg::ST_SLEEP;
        end else if (settle_ff == '0) begin
          nxt_state = gate_drive_pkg::ST_RUN;
        end else begin
          nxt_settle = settle_ff - 1'b1;
        end
      end
      gate_drive_pkg::ST_RUN: begin
        if (!sync2_ff.low_power_request_n) begin
          nxt_state = gate_drive_pkg::ST_SLEEP;
        end
      end
      default: begin
        nxt_state = gate_drive_pkg::ST_SLEEP;
      end
    endcase
  end

  // register the sequencer; reset enters the power-up settle window
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_ff <= gate_drive_pkg::ST_SETTLE;
      settle_ff <= SETTLE_LOAD;
    end else begin
      state_ff <= nxt_state;
      settle_ff <= nxt_settle;
    end
  end

  // dead-time choice; the resistor formula rounds up to whole cycles
  always_comb begin
    dt_ns_x = 16'(gate_drive_pkg::DT_SLOPE_NS) * 16'(sync2_ff.dt_kohm) + 16'(gate_drive_pkg::DT_OFFSET_NS);
    if (sync2_ff.dt_tied_gnd) begin
      nxt_dt_cycles = DT_GND_LOAD;
    end else if (sync2_ff.dt_open) begin
      nxt_dt_cycles = DT_OPEN_LOAD;
    end else begin
      nxt_dt_cycles = gate_drive_pkg::DT_W'((32'(dt_ns_x) * gate_drive_pkg::CLK_MHZ + 999) / 1000);
    end
  end

  // fault: supply low or over-temperature; bootstrap low never reports; released in sleep
  always_comb begin
    nxt_fault = (state_ff != gate_drive_pkg::ST_SLEEP) && sync2_ff.low_power_request_n &&
                (sync2_ff.supply_low_lockout || sync2_ff.over_temp);
  end

  // register dead time and fault level
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      dt_cycles_ff <= DT_GND_LOAD;
      fault_ff <= 1'b0;
    end else begin
      dt_cycles_ff <= nxt_dt_cycles;
      fault_ff <= nxt_fault;
    end
  end

  // gates run only in run state with no lockout; otherwise the phase drives both gates low
  assign drive_en = (state_ff == gate_drive_pkg::ST_RUN) && sync2_ff.low_power_request_n &&
                    !sync2_ff.supply_low_lockout && !sync2_ff.over_temp;

  // the pin only ever pulls low; the external pull-up gives the high level
  assign error_report_n_out = 1'b0;
  assign error_report_n_oe = fault_ff;

  // one identical phase slice per half-bridge
  for (genvar ph = 0; ph < gate_drive_pkg::NUM_PHASES; ph++) begin : g_phase
    dead_time_phase u_phase (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .drive_en(drive_en),
      .dt_cycles(dt_cycles_ff),
      .high_side_cmd(sync2_ff.high_side_cmd[ph]),
      .low_side_cmd(sync2_ff.low_side_cmd[ph]),
      .bootstrap_low(sync2_ff.bootstrap_low[ph]),
      .high_gate_out(gates.high_gate_out[ph]),
      .low_gate_out(gates.low_gate_out[ph])
    );
  end

  // assertions
  property p_settle_off;
    @(posedge ref_clk) disable iff (!rst_n)
      (state_ff == gate_drive_pkg::ST_SETTLE) |=> (gates == '0);
  endproperty
  a_settle_off: assert property (p_settle_off) else $error("gate on during settle window");

  property p_settle_len;
    @(posedge ref_clk) disable iff (!rst_n)
      (state_ff == gate_drive_pkg::ST_SETTLE) && (settle_ff != '0) |=> (state_ff != gate_drive_pkg::ST_RUN);
  endproperty
  a_settle_len: assert property (p_settle_len) else $error("run entered before settle count expired");

  property p_sleep_off;
    @(posedge ref_clk) disable iff (!rst_n)
      !sync2_ff.low_power_request_n |=> (gates == '0) && (state_ff == gate_drive_pkg::ST_SLEEP);
  endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("sleep request not honoured");

  property p_lockout_off;
    @(posedge ref_clk) disable iff (!rst_n)
      sync2_ff.supply_low_lockout |=> (gates == '0);
  endproperty
  a_lockout_off: assert property (p_lockout_off) else $error("gate on under supply lockout");

  property p_otp_off;
    @(posedge ref_clk) disable iff (!rst_n) sync2_ff.over_temp |=> (gates == '0);
  endproperty
  a_otp_off: assert property (p_otp_off) else $error("gate on under over-temperature");

  property p_fault_report;
    @(posedge ref_clk) disable iff (!rst_n)
      (state_ff == gate_drive_pkg::ST_RUN) && sync2_ff.low_power_request_n &&
      (sync2_ff.supply_low_lockout || sync2_ff.over_temp) |=> error_report_n_oe;
  endproperty
  a_fault_report: assert property (p_fault_report) else $error("fault not reported");

  property p_fault_release;
    @(posedge ref_clk) disable iff (!rst_n)
      !sync2_ff.supply_low_lockout && !sync2_ff.over_temp |=> !error_report_n_oe;
  endproperty
  a_fault_release: assert property (p_fault_release) else $error("fault pin held after clear");

  property p_dt_gnd;
    @(posedge ref_clk) disable iff (!rst_n) sync2_ff.dt_tied_gnd |=> (dt_cycles_ff == 12'h008);
  endproperty
  a_dt_gnd: assert property (p_dt_gnd) else $error("grounded dead time wrong");

  property p_dt_open;
    @(posedge ref_clk) disable iff (!rst_n)
      !sync2_ff.dt_tied_gnd && sync2_ff.dt_open |=> (dt_cycles_ff == 12'h258);
  endproperty
  a_dt_open: assert property (p_dt_open) else $error("open dead time wrong");
endmodule

// file: inc/gate_drive_pkg.sv
// shared constants and carrier types of the three-phase gate drive control
package gate_drive_pkg;
  localparam int CLK_MHZ = 100;            // ref_clk rate
  localparam int NUM_PHASES = 3;
  localparam int SYNC_RESET_VAL = 0;       // synchroniser flops clear to zero
  // power-up and wake-up settling
  localparam int SETTLE_TIME_US = 70;
  localparam int SETTLE_CYCLES = SETTLE_TIME_US * CLK_MHZ;
  localparam int SETTLE_W = 13;            // wide enough for the settle count
  // dead time: slope per kilo-ohm and fixed offset, in ns
  localparam int DT_SLOPE_NS = 44;
  localparam int DT_OFFSET_NS = 100;
  localparam int DT_GND_NS = 77;           // pin tied to ground
  localparam int DT_OPEN_US = 6;           // pin left open
  localparam int DT_GND_CYCLES = (DT_GND_NS * CLK_MHZ + 999) / 1000;
  localparam int DT_OPEN_CYCLES = DT_OPEN_US * CLK_MHZ;
  localparam int DT_W = 12;                // dead-time count width
  localparam int DT_MIN_CYCLES = 8;        // least dead time of any setting
  localparam int KOHM_W = 8;               // resistor code width

  // sequencer states, gray along sleep -> settle -> run
  typedef enum logic [1:0] {
    ST_SLEEP = 2'h0,
    ST_SETTLE = 2'h1,
    ST_RUN = 2'h3
  } seq_state_t;

  // everything that arrives on pins
  typedef struct packed {
    logic low_power_request_n;
    logic supply_low_lockout;
    logic over_temp;
    logic [NUM_PHASES-1:0] high_side_cmd;
    logic [NUM_PHASES-1:0] low_side_cmd;
    logic [NUM_PHASES-1:0] bootstrap_low;
    logic dt_tied_gnd;
    logic dt_open;
    logic [KOHM_W-1:0] dt_kohm;
  } pin_in_t;

  // gate enables toward the drivers
  typedef struct packed {
    logic [NUM_PHASES-1:0] high_gate_out;
    logic [NUM_PHASES-1:0] low_gate_out;
  } gate_out_t;
endpackage

// file: tb/motor_ctrl_model.sv
// controller model: per-phase commands, bootstrap pre-charge and wake wait
`timescale 1ns/100ps
module motor_ctrl_model #(
  parameter int SETTLE_CYCLES = 20  // settle window of the device under test
) (
  // clock
  input wire logic ref_clk,
  // commands toward the pre-driver
  output logic [2:0] high_side_cmd,
  output logic [2:0] low_side_cmd
);
  // all phases idle at time zero
  initial begin
    high_side_cmd = 3'h0;
    low_side_cmd = 3'h0;
  end
  // commands change just after a falling edge, never on the sampling edge
  task automatic set_phase(input int ph, input logic hs, input logic ls);
    @(negedge ref_clk);
    high_side_cmd[ph] = hs;
    low_side_cmd[ph] = ls;
  endtask
  // low side on, one phase at a time, 20% duty so the boot diode stays cool
  task automatic precharge(input int pulses);
    for (int ph = 0; ph < 3; ph++) begin
      for (int p = 0; p < pulses; p++) begin
        set_phase(ph, 1'b0, 1'b1);
        repeat (9) @(negedge ref_clk);
        set_phase(ph, 1'b0, 1'b0);
        repeat (39) @(negedge ref_clk);
      end
    end
  endtask
  // no new command until the wake-up window has surely run out
  task automatic wake_wait();
    repeat (SETTLE_CYCLES + 8) @(negedge ref_clk);
  endtask
endmodule

// file: tb/test_three_phase_gate_drive_control.sv
// self-checking bench of the three-phase gate drive control
`timescale 1ns/100ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin mismatches++; $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module test_three_phase_gate_drive_control;
  localparam int SETTLE = 20;  // short settle window keeps the run brief
  logic ref_clk;
  logic rst_n;
  gate_drive_pkg::pin_in_t ctl;  // bench pins; commands come from the model
  gate_drive_pkg::pin_in_t pins;
  gate_drive_pkg::gate_out_t gates;
  logic err_out;
  logic err_oe;
  logic [2:0] hs_cmd;
  logic [2:0] ls_cmd;
  logic [6:0] obs;  // fault pin level, high gates, low gates
  int n_cyc;  // cycles spent in the last wait
  int mismatches = 0;
  int total_checks = 0;
  // pull-up holds the fault pin high unless the device pulls it low
  assign obs = {err_oe ? err_out : 1'b1, gates.high_gate_out, gates.low_gate_out};
  // overlay the controller's commands on the bench pins
  always_comb begin
    pins = ctl;
    pins.high_side_cmd = hs_cmd;
    pins.low_side_cmd = ls_cmd;
  end
  three_phase_gate_drive_control #(.SETTLE_CYCLES(SETTLE)) three_phase_gate_drive_control_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .pins_in(pins), .gates(gates),
    .error_report_n_out(err_out), .error_report_n_oe(err_oe));
  motor_ctrl_model #(.SETTLE_CYCLES(SETTLE)) motor_ctrl_model_inst (
    .ref_clk(ref_clk), .high_side_cmd(hs_cmd), .low_side_cmd(ls_cmd));
  task automatic cyc(input int k);
    repeat (k) @(negedge ref_clk);
  endtask
  task automatic cmd(input int ph, input logic hs, input logic ls);
    motor_ctrl_model_inst.set_phase(ph, hs, ls);
  endtask
  // bounded wait for one observed bit, counted in cycles
  task automatic wait_on(input int b, input logic v, input int lim);
    n_cyc = 0;
    while (obs[b] !== v && n_cyc < lim) begin
      @(negedge ref_clk);
      n_cyc++;
    end
    `CHK(obs[b], v)
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // command arriving right after release must wait out the settle window
  task automatic t_power_up();
    cmd(0, 1'b0, 1'b1);
    for (int i = 0; i < SETTLE; i++) begin
      @(negedge ref_clk);
      `CHK(obs[5:0], 6'h00)
    end
    wait_on(0, 1'b1, 20);
    cmd(0, 1'b0, 1'b0);
    cyc(12);
    motor_ctrl_model_inst.precharge(2);
  endtask
  // every command pattern on every phase
  task automatic t_truth();
    for (int p = 0; p < 3; p++) begin
      cmd(p, 1'b0, 1'b1);
      wait_on(p, 1'b1, 20);
      `CHK(obs[3+p], 1'b0)
      cmd(p, 1'b1, 1'b1);
      wait_on(p, 1'b0, 10);
      cyc(12);
      `CHK(obs[5:0], 6'h00)
      cmd(p, 1'b1, 1'b0);
      wait_on(3 + p, 1'b1, 20);
      `CHK(obs[p], 1'b0)
      cmd(p, 1'b0, 1'b0);
      wait_on(3 + p, 1'b0, 10);
      cyc(12);
    end
  endtask
  // gap from low-side off to high-side on for one selection
  task automatic t_dead(input logic g, input logic o, input logic [7:0] k, input int exp);
    ctl.dt_tied_gnd = g;
    ctl.dt_open = o;
    ctl.dt_kohm = k;
    cyc(5);
    cmd(1, 1'b0, 1'b1);
    wait_on(1, 1'b1, 700);
    cmd(1, 1'b1, 1'b0);
    wait_on(1, 1'b0, 10);
    wait_on(4, 1'b1, 700);
    `CHK(n_cyc, exp)
    cmd(1, 1'b0, 1'b0);
    wait_on(4, 1'b0, 10);
    cyc(exp + 4);
  endtask
  // weak bootstrap drops only that high side, fault pin stays high
  task automatic t_boot();
    cmd(2, 1'b1, 1'b0);
    wait_on(5, 1'b1, 20);
    ctl.bootstrap_low[2] = 1'b1;
    wait_on(5, 1'b0, 10);
    cyc(3);
    `CHK(obs[6:2], 5'h10)
    ctl.bootstrap_low[2] = 1'b0;
    wait_on(5, 1'b1, 20);
    cmd(2, 1'b0, 1'b0);
    wait_on(5, 1'b0, 10);
    cyc(12);
  endtask
  // supply low (which 0) or over-temperature (which 1), then auto resume
  task automatic t_fault(input int which);
    cmd(0, 1'b0, 1'b1);
    wait_on(0, 1'b1, 20);
    if (which == 0) begin
      ctl.supply_low_lockout = 1'b1;
    end else begin
      ctl.over_temp = 1'b1;
    end
    wait_on(0, 1'b0, 10);
    wait_on(6, 1'b0, 10);
    `CHK(obs[5:0], 6'h00)
    ctl.supply_low_lockout = 1'b0;
    ctl.over_temp = 1'b0;
    wait_on(6, 1'b1, 10);
    wait_on(0, 1'b1, 20);
    cmd(0, 1'b0, 1'b0);
    wait_on(0, 1'b0, 10);
    cyc(12);
  endtask
  // sleep ignores commands and faults; wake re-runs the settle window
  task automatic t_sleep();
    cmd(0, 1'b0, 1'b1);
    wait_on(0, 1'b1, 20);
    ctl.low_power_request_n = 1'b0;
    wait_on(0, 1'b0, 10);
    ctl.over_temp = 1'b1;
    cmd(1, 1'b1, 1'b0);
    cyc(8);
    `CHK(obs, 7'h40)
    ctl.over_temp = 1'b0;
    cmd(0, 1'b0, 1'b0);
    cyc(4);
    ctl.low_power_request_n = 1'b1;
    cyc(SETTLE);
    `CHK(obs[5:0], 6'h00)
    motor_ctrl_model_inst.wake_wait();
    wait_on(4, 1'b1, 20);
    cmd(1, 1'b0, 1'b0);
    cyc(12);
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // watchdog well beyond the few thousand cycles the tests need
  initial begin
    #200us;
    mismatches++;
    $display("[FAIL] %0t watchdog expired", $time);
    finish_test();
  end
  initial begin
    rst_n = 1'b0;
    ctl = '0;
    ctl.low_power_request_n = 1'b1;
    ctl.dt_tied_gnd = 1'b1;
    cyc(2);
    rst_n = 1'b1;
    t_power_up();
    t_truth();
    t_dead(1'b1, 1'b0, 8'h00, 8);
    t_dead(1'b0, 1'b1, 8'h00, 600);
    t_dead(1'b0, 1'b0, 8'h05, 32);
    t_dead(1'b1, 1'b1, 8'h05, 8);
    t_boot();
    t_fault(0);
    t_fault(1);
    t_sleep();
    finish_test();
  end
endmodule
